// ---- pims_top.sv ----
// Purpose: Interrupt mask and pending-status registers of a copper PHY
// Assumes: Event inputs are one-cycle pulses synchronous to sys_clk;
//          the management port gives one-cycle read and write strobes
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module pims_top (
   input wire logic sys_clk, // System clock, 50 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic soft_rst, // Software reset pulse
   input wire logic sticky_rst_en, // Keep sticky bits on soft reset
   input wire logic [4:0] reg_addr, // Register address
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [15:0] reg_wdata, // Write data
   output logic [15:0] reg_rdata, // Read data, one cycle after strobe
   output logic reg_rvalid, // Read data valid pulse
   input wire logic autoneg_en, // Autonegotiation enabled
   input wire logic [3:0] adv_bits, // Advertisement bits 8 to 5
   input wire logic rx_er_carrier_ext, // RX error used as extension
   input wire logic ev_speed, // Speed state change
   input wire logic ev_link, // Link state change
   input wire logic ev_duplex, // Duplex state change
   input wire logic ev_an_err, // Autonegotiation error
   input wire logic ev_an_done, // Autonegotiation complete
   input wire logic ev_pd_det, // Powered device detected
   input wire logic ev_sym_err, // Symbol error
   input wire logic ev_fast_lf, // Fast link failure
   input wire logic ev_ext, // Extended event, cause held elsewhere
   input wire logic ev_false_car, // False carrier
   input wire logic ev_downshift, // Speed downshift
   input wire logic ev_ms_fault, // Master/slave resolution fault
   input wire logic ev_rx_err, // Receive error
   output logic irq_out_pin, // Interrupt pin level, high when pending and mask bit 15 set
   output logic irq_out_pin_oe // Interrupt pin output enable
);
   pims_flag_if fif ();

   logic [15:0] mask;
   logic [15:0] next_mask;
   logic [15:0] next_rdata;
   logic [14:0] raw_src;
   logic [14:0] qual_src;
   logic [15:0] status_word;
   logic pending;
   logic hit_mask_wr;
   logic hit_stat_rd;
   logic hit_mask_rd;
   logic keep_sticky;
   logic next_pin;
   logic next_oe;
   logic [14:0] next_flags_seen;
   logic adv_full;
   // Gated event sources, one per status position except 6 and 4
   logic src_speed;
   logic src_link;
   logic src_duplex;
   logic src_an_err;
   logic src_an_done;
   logic src_pd_det;
   logic src_sym_err;
   logic src_fast_lf;
   logic src_ext;
   logic src_false_car;
   logic src_downshift;
   logic src_ms_fault;
   logic src_rx_err;

   function automatic logic addr_is(input logic [4:0] a,
                                    input logic [4:0] ref_a);
      addr_is = (a == ref_a);
   endfunction

   pims_flag_bank u_bank (
      .sys_clk(sys_clk),
      .rst(rst),
      .fb(fif.bank)
   );

   // Gating conditions for individual sources
   assign adv_full = (adv_bits == pims_pkg::ADV_ALL);
   assign src_speed = ev_speed & autoneg_en;
   assign src_link = ev_link;
   assign src_duplex = ev_duplex & autoneg_en;
   assign src_an_err = ev_an_err;
   assign src_an_done = ev_an_done;
   assign src_pd_det = ev_pd_det;
   assign src_sym_err = ev_sym_err;
   assign src_fast_lf = ev_fast_lf;
   assign src_ext = ev_ext;
   assign src_false_car = ev_false_car;
   assign src_downshift = ev_downshift & adv_full;
   assign src_ms_fault = ev_ms_fault;
   // Carrier extension reuses the error line, so it is no error
   assign src_rx_err = ev_rx_err & ~rx_er_carrier_ext;

   // Place each source at its status position; 6 and 4 stay zero
   always_comb begin
      raw_src = '0;
      raw_src[pims_pkg::BIT_SPEED] = src_speed;
      raw_src[pims_pkg::BIT_LINK] = src_link;
      raw_src[pims_pkg::BIT_DUPLEX] = src_duplex;
      raw_src[pims_pkg::BIT_AN_ERR] = src_an_err;
      raw_src[pims_pkg::BIT_AN_DONE] = src_an_done;
      raw_src[pims_pkg::BIT_PD_DET] = src_pd_det;
      raw_src[pims_pkg::BIT_SYM_ERR] = src_sym_err;
      raw_src[pims_pkg::BIT_FAST_LF] = src_fast_lf;
      raw_src[pims_pkg::BIT_EXT] = src_ext;
      raw_src[pims_pkg::BIT_FALSE_CAR] = src_false_car;
      raw_src[pims_pkg::BIT_DOWNSHIFT] = src_downshift;
      raw_src[pims_pkg::BIT_MS_FAULT] = src_ms_fault;
      raw_src[pims_pkg::BIT_RX_ERR] = src_rx_err;
   end

   // Only enabled, non-reserved sources report
   assign qual_src = raw_src & mask[14:0] &
      pims_pkg::SRC_VALID;

   // Register decode; the address is taken with the strobe
   assign hit_mask_wr = reg_wr & addr_is(reg_addr, pims_pkg::ADDR_MASK);
   assign hit_mask_rd = reg_rd & addr_is(reg_addr, pims_pkg::ADDR_MASK);
   assign hit_stat_rd = reg_rd & addr_is(reg_addr, pims_pkg::ADDR_STAT);
   // Soft reset spares the mask only with sticky enabled
   assign keep_sticky = soft_rst & sticky_rst_en;

   // Summary bit is not stored; it is the OR of the causes
   assign pending = |fif.flags;
   assign status_word = {pending, fif.flags};

   // Reading status clears exactly the bits seen as one
   assign fif.set_req = qual_src;
   assign fif.clr_req = hit_stat_rd ? fif.flags : '0;
   assign fif.flush = soft_rst;

   // Mask: write, sticky over soft reset when enabled
   always_comb begin
      next_mask = mask;
      if (soft_rst && !keep_sticky) begin
         next_mask = pims_pkg::MASK_RST;
      end else if (hit_mask_wr) begin
         next_mask = reg_wdata;
      end
   end

   // Read mux; status has no write path
   always_comb begin
      next_rdata = '0;
      if (hit_mask_rd) begin
         next_rdata = mask;
      end else if (hit_stat_rd) begin
         next_rdata = status_word;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mask <= pims_pkg::MASK_RST;
      end else begin
         mask <= next_mask;
      end
   end

   // Read data stands one cycle, then falls back to zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= pims_pkg::RDATA_RST;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Valid marks the one cycle the read data stands
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // Pending level the flag bank will hold next cycle
   assign next_flags_seen = (qual_src | (fif.flags & ~fif.clr_req &
      {15{~soft_rst}})) & pims_pkg::SRC_VALID;

   // Pin registers take the next state so pin and flag move together
   assign next_oe = next_mask[pims_pkg::BIT_PEND];
   assign next_pin = next_oe & (|next_flags_seen);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_out_pin <= 1'b0;
      end else begin
         irq_out_pin <= next_pin;
      end
   end

   // Clearing mask bit 15 only parks the pin; flags keep latching
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_out_pin_oe <= 1'b0;
      end else begin
         irq_out_pin_oe <= next_oe;
      end
   end
endmodule // pims_top

// ---- pims_pkg.sv ----
// Purpose: Shared constants for the PHY interrupt mask and status block
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   Used by pims_flag_bank and pims_top
package pims_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned SRC_W = 15;
   localparam int unsigned ADV_W = 4;

   // Register addresses
   localparam logic [4:0] ADDR_MASK = 5'h19;
   localparam logic [4:0] ADDR_STAT = 5'h1A;

   // Reset values
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [14:0] FLAG_RST = 15'h0000;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   // Bit positions
   localparam int unsigned BIT_PEND = 15;
   localparam int unsigned BIT_SPEED = 14;
   localparam int unsigned BIT_LINK = 13;
   localparam int unsigned BIT_DUPLEX = 12;
   localparam int unsigned BIT_AN_ERR = 11;
   localparam int unsigned BIT_AN_DONE = 10;
   localparam int unsigned BIT_PD_DET = 9;
   localparam int unsigned BIT_SYM_ERR = 8;
   localparam int unsigned BIT_FAST_LF = 7;
   localparam int unsigned BIT_EXT = 5;
   localparam int unsigned BIT_FALSE_CAR = 3;
   localparam int unsigned BIT_DOWNSHIFT = 2;
   localparam int unsigned BIT_MS_FAULT = 1;
   localparam int unsigned BIT_RX_ERR = 0;

   // Positions 6 and 4 carry no event source
   localparam logic [14:0] SRC_VALID = 15'h7FAF;
   localparam logic [3:0] ADV_ALL = 4'hF;
endpackage

// ---- pims_flag_if.sv ----
// Purpose: Carrier between the top and the pending-flag bank
// Assumes: One clock domain
// Notes:   Top drives sources and clear; bank returns the flags
`timescale 1ns/1ps
interface pims_flag_if;
   logic [14:0] set_req;
   logic [14:0] clr_req;
   logic flush;
   logic [14:0] flags;
   modport ctrl (output set_req, output clr_req, output flush,
                 input flags);
   modport bank (input set_req, input clr_req, input flush,
                 output flags);
endinterface // pims_flag_if

// ---- pims_flag_bank.sv ----
// Purpose: Thirteen latched event flags in fifteen positions, with clear-on-read
// Assumes: Set and clear requests are single-cycle
// Notes:   A set in the clearing cycle survives
`timescale 1ns/1ps
module pims_flag_bank (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   pims_flag_if.bank fb // Flag requests and state
);
   logic [14:0] next_flags;

   genvar i;
   generate
      for (i = 0; i < 15; i++) begin : g_flag
         if (pims_pkg::SRC_VALID[i]) begin : g_src
            // Set wins over clear
            assign next_flags[i] = fb.set_req[i] |
               (fb.flags[i] & ~fb.clr_req[i] & ~fb.flush);
         end else begin : g_rsv
            assign next_flags[i] = 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fb.flags <= pims_pkg::FLAG_RST;
      end else begin
         fb.flags <= next_flags;
      end
   end
endmodule // pims_flag_bank

// ---- pims_sva.sv ----
// Purpose: Port assertions for pims_top
// Assumes: Sees top ports only
// Notes: Bound from tb_top
`timescale 1ns/1ps
module pims_sva (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic soft_rst, // Soft reset
   input wire logic sticky_rst_en, // Keep mask
   input wire logic [4:0] reg_addr, // Address
   input wire logic reg_wr, // Write
   input wire logic reg_rd, // Read
   input wire logic [15:0] reg_wdata, // Write data
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic reg_rvalid, // Read valid
   input wire logic irq_out_pin, // Pin level
   input wire logic irq_out_pin_oe // Pin enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire is_stat = reg_addr == pims_pkg::ADDR_STAT;
   wire is_mask = reg_addr == pims_pkg::ADDR_MASK;
   sequence s_rd_stat; reg_rd && is_stat; endsequence
   sequence s_wr_mask; reg_wr && is_mask && !soft_rst; endsequence
   property p_rvalid; reg_rd |=> reg_rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("no rvalid");
   property p_idle; !reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("idle rdata");
   property p_sum; s_rd_stat |=> reg_rdata[15] == |reg_rdata[14:0];
   endproperty
   a_sum: assert property (p_sum) else $error("summary bit");
   property p_oe; s_wr_mask |=> irq_out_pin_oe == $past(reg_wdata[15]);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable");
   property p_gate; !irq_out_pin_oe |-> !irq_out_pin; endproperty
   a_gate: assert property (p_gate) else $error("pin gated");
   property p_pin; s_rd_stat ##0 irq_out_pin_oe
      |=> reg_rdata[15] == $past(irq_out_pin); endproperty
   a_pin: assert property (p_pin) else $error("pin follow");
   property p_soft; soft_rst && !sticky_rst_en && !reg_wr
      |=> !irq_out_pin_oe; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   property p_unmap; reg_rd && !is_stat && !is_mask |=> reg_rdata == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule // pims_sva

// ---- pims_host.sv ----
// Purpose: Management host model for the register port
// Assumes: One-cycle strobes, data one cycle later
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
module pims_host (
   input wire logic sys_clk, // Clock
   input wire logic [15:0] reg_rdata, // Read data
   output logic [4:0] reg_addr, // Address
   output logic reg_wr, // Write strobe
   output logic reg_rd, // Read strobe
   output logic [15:0] reg_wdata // Write data
);
   initial begin
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic xfer(input logic w, input logic [4:0] a,
      input logic [15:0] d, output logic [15:0] q);
      @(posedge sys_clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge sys_clk);
      #1 reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      q = reg_rdata;
   endtask
   // Stale events flushed before the pin goes live
   task automatic pin_on(input logic [15:0] m);
      logic [15:0] q;
      xfer(1'b0, pims_pkg::ADDR_STAT, 16'h0000, q);
      xfer(1'b1, pims_pkg::ADDR_MASK, m, q);
   endtask
endmodule // pims_host

// ---- tb_top.sv ----
// Purpose: Self-checking bench for pims_top
// Assumes: Host model drives the register port
// Notes: Events driven as one vector
`timescale 1ns/1ps
module tb_top;
   localparam logic [4:0] M = pims_pkg::ADDR_MASK;
   localparam logic [4:0] S = pims_pkg::ADDR_STAT;
   logic sys_clk = 0, rst = 1, soft_rst = 0, sticky_rst_en = 0;
   logic an = 1, rx_ext = 0, reg_wr, reg_rd, reg_rvalid;
   logic irq_out_pin, irq_out_pin_oe;
   logic [15:0] pins;
   assign pins = {14'h0000, irq_out_pin, irq_out_pin_oe};
   logic [3:0] adv = 4'hF;
   logic [14:0] ev = 15'h0000;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   int failures = 0, num_checks = 0, cycles = 0;
   pims_top DUT (.sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
      .sticky_rst_en(sticky_rst_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .autoneg_en(an), .adv_bits(adv),
      .rx_er_carrier_ext(rx_ext), .ev_speed(ev[14]), .ev_link(ev[13]),
      .ev_duplex(ev[12]), .ev_an_err(ev[11]), .ev_an_done(ev[10]),
      .ev_pd_det(ev[9]), .ev_sym_err(ev[8]), .ev_fast_lf(ev[7]),
      .ev_ext(ev[5]), .ev_false_car(ev[3]), .ev_downshift(ev[2]),
      .ev_ms_fault(ev[1]), .ev_rx_err(ev[0]), .irq_out_pin(irq_out_pin),
      .irq_out_pin_oe(irq_out_pin_oe));
   pims_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         complete_run;
      end
   end
   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] s, e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e, string n);
      logic [15:0] q;
      host.xfer(1'b0, a, 16'h0000, q);
      chk("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
      chk(n, q, e);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic pulse(input int b);
      @(posedge sys_clk);
      #1 ev[b] = 1'b1;
      @(posedge sys_clk);
      #1 ev[b] = 1'b0;
   endtask
   task automatic soft_pulse;
      @(posedge sys_clk);
      #1 soft_rst = 1'b1;
      @(posedge sys_clk);
      #1 soft_rst = 1'b0;
   endtask
   task automatic t_regs;
      chk("pins", pins, 16'h0000);
      rd(M, 16'h0000, "mask rst");
      wr(M, 16'hFFFF);
      rd(M, 16'hFFFF, "mask rw");
      wr(S, 16'hFFFF);
      rd(S, 16'h0000, "stat ro");
      rd(5'h1B, 16'h0000, "unmapped");
   endtask
   task automatic t_events;
      for (int b = 0; b < 15; b++) begin
         if (pims_pkg::SRC_VALID[b]) begin
            pulse(b);
            chk("pin up", pins, 16'h0003);
            rd(S, 16'h8000 | (16'h0001 << b), "cause");
            rd(S, 16'h0000, "cleared");
            chk("pin clr", pins, 16'h0001);
         end
      end
   endtask
   task automatic t_gate;
      an = 1'b0;
      adv = 4'h7;
      rx_ext = 1'b1;
      pulse(14);
      pulse(12);
      pulse(2);
      pulse(0);
      rd(S, 16'h0000, "gated");
      an = 1'b1;
      adv = 4'hF;
      rx_ext = 1'b0;
      wr(M, 16'h8000);
      pulse(13);
      rd(S, 16'h0000, "masked");
   endtask
   task automatic t_pin;
      host.pin_on(16'hA000);
      pulse(13);
      fork
         rd(S, 16'hA000, "first");
         pulse(13);
      join
      rd(S, 16'hA000, "kept");
      chk("pin down", {15'h0000, irq_out_pin}, 16'h0000);
      wr(M, 16'h2000);
      pulse(13);
      chk("pin off", pins, 16'h0000);
      rd(S, 16'hA000, "latched");
   endtask
   task automatic t_soft;
      wr(M, 16'h8001);
      sticky_rst_en = 1'b1;
      pulse(0);
      soft_pulse;
      rd(M, 16'h8001, "sticky");
      rd(S, 16'h0000, "flushed");
      sticky_rst_en = 1'b0;
      soft_pulse;
      rd(M, 16'h0000, "default");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst = 1'b0;
      t_regs;
      t_events;
      t_gate;
      t_pin;
      t_soft;
      complete_run;
   end
endmodule // tb_top
bind pims_top pims_sva u_sva (.sys_clk(sys_clk), .rst(rst),
   .soft_rst(soft_rst), .sticky_rst_en(sticky_rst_en),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .irq_out_pin(irq_out_pin), .irq_out_pin_oe(irq_out_pin_oe));
